// ===== logic/io_expander_map.svh
/*
 Register indices, reset values and address constants of the sixteen-line I/O expander.
 Assumes that it is included by its bare name, after the package, into the design files.
*/
// What this block does
// R1: Two 8-bit ports, each with configuration, input, output and polarity registers.
// R2: After reset every line is an input until the master changes it.
// R3: A configuration bit picks input or output and the line follows it.
// R4: Input register shows sampled pins, output register holds driven values.
// R5: A set polarity bit makes the input register show the inverted pin.
// R6: All interrupt masks are set at reset, so no line can interrupt.
// R7: Reset returns every register to default and restarts the serial slave.
// R8: The active-low reset pin acts like power-on reset; ref_r loads the live pins after the pin reset, but zeros after rst_i.
// R9: Interrupt asserts while any input differs from its input register state.
// R10: Interrupt output is active low, open-drain, pulls low only when asserted.
// R11: A latched line holds its interrupting value until the input register is read.
// R12: A set mask bit stops that line from asserting the interrupt.
// R13: A read-only status register shows which lines caused the interrupt.
// R14: Each 8-bit bank is push-pull or open-drain by software choice.
// R15: Each output line has one of four drive strengths.
// R16: Each line has an enable that connects its pull resistor or floats.
// R17: A per-line select points the enabled pull resistor up or down.
// R18: One strap input picks one of two fixed slave addresses.
// R19: Interrupt clears on input register read or when inputs return.
// R20: The master writes a pointer byte, then reads or writes data bytes.
`ifndef IO_EXPANDER_MAP_SVH
`define IO_EXPANDER_MAP_SVH
// Register index = group * 2 + port; the bus byte address is index * 4.
`define GRP_IN    4'h0
`define GRP_OUT   4'h1
`define GRP_POL   4'h2
`define GRP_CFG   4'h3
`define GRP_DRV0  4'h4
`define GRP_DRV1  4'h5
`define GRP_LAT   4'h6
`define GRP_PEN   4'h7
`define GRP_PSEL  4'h8
`define GRP_MASK  4'h9
`define GRP_STAT  4'hA
`define GRP_ODM   4'hB
`define REG_LAST  5'h16
`define RST_OUT   16'hFFFF
`define RST_POL   16'h0000
`define RST_CFG   16'hFFFF
`define RST_DRV   32'hFFFFFFFF
`define RST_LAT   16'h0000
`define RST_PEN   16'h0000
`define RST_PSEL  16'hFFFF
`define RST_MASK  16'hFFFF
`define RST_ODM   2'h0
`define SLV_ADDR_HI 6'h10
`define SYNC_RST  20'h0000C
`endif

// ===== logic/io_expander_pkg.sv
/*
 Types shared by the I/O expander design files.
 Assumes nothing of its surroundings.
*/
package io_expander_pkg;
   typedef enum logic [2:0] {
      S_IDLE  = 3'h0,
      S_ADDR  = 3'h1,
      S_AACK  = 3'h2,
      S_PTR   = 3'h3,
      S_DACK  = 3'h4,
      S_WDATA = 3'h5,
      S_RDATA = 3'h6,
      S_RACK  = 3'h7
   } slv_state_t;
endpackage

// ===== logic/sync2.sv
/*
 Two flip-flop synchroniser for a group of independent level inputs.
 Assumes that each bit is a slow level; words are not kept coherent.
*/
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
   parameter int         W  = 1,
   parameter logic [W-1:0] RV = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic [W-1:0]      q_o
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= RV;
         q_o    <= RV;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ===== logic/io_expander.sv
/*
 Sixteen-line I/O expander: register file, pin control, input latching, interrupt,
 a serial bus slave on sampled clock and data lines, and a classic Wishbone slave.
 Assumes a 100 MHz clk_i, pins that are asynchronous to it, and an external pull-up on
 the serial data line and on the interrupt line.
*/
`timescale 1ns/10ps
`default_nettype none
`include "io_expander_map.svh"
module io_expander (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        reset_n_i,
   input  wire logic        addr_sel_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   input  wire logic [15:0] gpio_i,
   output logic [15:0]      gpio_o,
   output logic [15:0]      gpio_oe_o,
   output logic [15:0]      pull_en_o,
   output logic [15:0]      pull_up_o,
   output logic [31:0]      drive_o,
   output logic             irq_n_o,
   output logic             irq_oe_o
);
   logic [19:0] sync_q;
   logic [15:0] pin_s;
   logic        scl_s;
   logic        sda_s;
   logic        rstn_s;
   logic        strap_s;
   logic        rst_any;

   logic [15:0] out_r;
   logic [15:0] pol_r;
   logic [15:0] cfg_r;
   logic [31:0] drv_r;
   logic [15:0] lat_en_r;
   logic [15:0] pen_r;
   logic [15:0] psel_r;
   logic [15:0] mask_r;
   logic [1:0]  odm_r;
   logic [15:0] odv;

   logic [15:0] hold_r;
   logic [15:0] cap_r;
   logic [15:0] ref_r;
   logic [15:0] live;
   logic [15:0] in_val;
   logic [15:0] status;
   logic [15:0] cap;
   logic [15:0] clr;
   logic [15:0] track;

   logic        acc_wr;
   logic        acc_rd;
   logic [5:0]  acc_idx;
   logic [7:0]  acc_wd;
   logic        rd_in;
   logic        wb_go;

   io_expander_pkg::slv_state_t st_r;
   logic [3:0]  bit_r;
   logic [7:0]  sh_r;
   logic [7:0]  tx_r;
   logic [4:0]  ptr_r;
   logic        rw_r;
   logic        nack_r;
   logic        strap_r;
   logic        strap_win_r;
   logic        scl_q;
   logic        sda_q;
   logic        i2c_wr_r;
   logic        i2c_rd_r;
   logic [4:0]  i2c_eidx_r;
   logic        i2c_ev;
   logic        start;
   logic        stop;
   logic        rise;
   logic        fall;
   logic        match;
   logic [7:0]  rd_byte;

   // Every pin passes two flops; the serial lines idle high so no false start is seen.
   sync2 #(
      .W  (20),
      .RV (`SYNC_RST)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({gpio_i, scl_i, sda_i, reset_n_i, addr_sel_i}),
      .q_o   (sync_q)
   );

   assign pin_s   = sync_q[19:4];
   assign scl_s   = sync_q[3];
   assign sda_s   = sync_q[2];
   assign rstn_s  = sync_q[1];
   assign strap_s = sync_q[0];
   assign rst_any = rst_i | ~rstn_s; // R7 R8

   function automatic logic [7:0] pick(input logic [15:0] v, input logic p); // R1
      pick = p ? v[15:8] : v[7:0];
   endfunction

   function automatic logic [7:0] reg_rd(input logic [5:0] idx);
      reg_rd = 8'h00;
      if (idx <= {1'b0, `REG_LAST}) begin
         case (idx[4:1])
            `GRP_IN:   reg_rd = pick(in_val, idx[0]); // R4
            `GRP_OUT:  reg_rd = pick(out_r, idx[0]);
            `GRP_POL:  reg_rd = pick(pol_r, idx[0]);
            `GRP_CFG:  reg_rd = pick(cfg_r, idx[0]);
            `GRP_DRV0,
            `GRP_DRV1: reg_rd = drv_r[{idx[1:0], 3'h0} +: 8];
            `GRP_LAT:  reg_rd = pick(lat_en_r, idx[0]);
            `GRP_PEN:  reg_rd = pick(pen_r, idx[0]);
            `GRP_PSEL: reg_rd = pick(psel_r, idx[0]);
            `GRP_MASK: reg_rd = pick(mask_r, idx[0]);
            `GRP_STAT: reg_rd = pick(status, idx[0]); // R13
            `GRP_ODM:  reg_rd = {6'h00, odm_r};
            default:   reg_rd = 8'h00;
         endcase
      end
   endfunction

   // A serial bus event owns the register port; a bus cycle waits one clock for it.
   assign i2c_ev  = i2c_wr_r | i2c_rd_r;
   assign wb_go   = cyc_i & stb_i & ~ack_o & ~i2c_ev;
   assign acc_idx = i2c_ev ? {1'b0, i2c_eidx_r} : adr_i[7:2];
   assign acc_wr  = i2c_wr_r | (wb_go & we_i & sel_i[0]);
   assign acc_rd  = i2c_rd_r | (wb_go & ~we_i);
   assign acc_wd  = i2c_wr_r ? sh_r : dat_i[7:0];
   assign rd_in   = acc_rd & (acc_idx[5:1] == {1'b0, `GRP_IN});
   assign clr     = {{8{rd_in & acc_idx[0]}}, {8{rd_in & ~acc_idx[0]}}};
   assign odv     = {{8{odm_r[1]}}, {8{odm_r[0]}}};
   assign live    = pin_s ^ pol_r; // R5

   for (genvar i = 0; i < 16; i++) begin : g_bit
      assign cap[i]    = lat_en_r[i] & cfg_r[i] & ~hold_r[i] & (live[i] ^ ref_r[i]); // R11
      assign in_val[i] = hold_r[i] ? cap_r[i] : live[i];
      assign status[i] = cfg_r[i] & ~mask_r[i] & (hold_r[i] | (live[i] ^ ref_r[i])); // R9 R12 R19
      assign track[i]  = clr[i] | ~cfg_r[i];
   end

   always_ff @(posedge clk_i) begin
      if (rst_any) begin
         out_r    <= `RST_OUT;
         pol_r    <= `RST_POL;
         cfg_r    <= `RST_CFG; // R2
         drv_r    <= `RST_DRV;
         lat_en_r <= `RST_LAT;
         pen_r    <= `RST_PEN;
         psel_r   <= `RST_PSEL;
         mask_r   <= `RST_MASK; // R6
         odm_r    <= `RST_ODM;
      end else if (acc_wr && !acc_idx[5]) begin
         case (acc_idx[4:1])
            `GRP_OUT:  out_r[{acc_idx[0], 3'h0} +: 8]    <= acc_wd;
            `GRP_POL:  pol_r[{acc_idx[0], 3'h0} +: 8]    <= acc_wd;
            `GRP_CFG:  cfg_r[{acc_idx[0], 3'h0} +: 8]    <= acc_wd; // R3
            `GRP_DRV0,
            `GRP_DRV1: drv_r[{acc_idx[1:0], 3'h0} +: 8]  <= acc_wd; // R15
            `GRP_LAT:  lat_en_r[{acc_idx[0], 3'h0} +: 8] <= acc_wd;
            `GRP_PEN:  pen_r[{acc_idx[0], 3'h0} +: 8]    <= acc_wd; // R16
            `GRP_PSEL: psel_r[{acc_idx[0], 3'h0} +: 8]   <= acc_wd; // R17
            `GRP_MASK: mask_r[{acc_idx[0], 3'h0} +: 8]   <= acc_wd;
            `GRP_ODM: begin
               if (!acc_idx[0]) begin
                  odm_r <= acc_wd[1:0]; // R14
               end
            end
            default: ;
         endcase
      end
   end

   // A capture in the cycle of a read wins, so a fresh change is never lost.
   always_ff @(posedge clk_i) begin
      if (rst_any) begin
         hold_r <= 16'h0000;
         cap_r  <= 16'h0000;
         ref_r  <= live;
      end else begin
         hold_r <= (hold_r & ~clr) | cap; // R11
         cap_r  <= (cap_r & ~cap) | (live & cap);
         ref_r  <= (ref_r & ~track) | (in_val & track); // R19
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_any) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= wb_go;
         if (wb_go && !we_i) begin
            dat_o <= {24'h000000, reg_rd(adr_i[7:2])};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_any) begin
         gpio_o    <= 16'h0000;
         gpio_oe_o <= 16'h0000;
         pull_en_o <= 16'h0000;
         pull_up_o <= 16'h0000;
         drive_o   <= 32'h00000000;
         irq_oe_o  <= 1'b0;
         irq_n_o   <= 1'b0;
         sda_o     <= 1'b0;
      end else begin
         gpio_o    <= out_r & ~odv; // R14
         gpio_oe_o <= ~cfg_r & (~odv | ~out_r); // R3 R14
         pull_en_o <= pen_r; // R16
         pull_up_o <= psel_r; // R17
         drive_o   <= drv_r; // R15
         irq_oe_o  <= |status; // R9 R10
         irq_n_o   <= 1'b0; // R10
         sda_o     <= 1'b0;
      end
   end

   assign start   = scl_s & scl_q & sda_q & ~sda_s;
   assign stop    = scl_s & scl_q & ~sda_q & sda_s;
   assign rise    = scl_s & ~scl_q;
   assign fall    = ~scl_s & scl_q;
   assign match   = sh_r[7:1] == {`SLV_ADDR_HI, strap_r}; // R18
   assign rd_byte = reg_rd({1'b0, ptr_r});

   // The strap shares the synchroniser with the reset pin, so its settled value only
   // arrives in the cycle after reset ends; it is caught then and frozen afterwards.
   always_ff @(posedge clk_i) begin
      strap_win_r <= rst_any;
      if (rst_any || strap_win_r) begin
         strap_r <= strap_s; // R18
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_any) begin
         st_r       <= io_expander_pkg::S_IDLE; // R7
         bit_r      <= 4'h0;
         sh_r       <= 8'h00;
         tx_r       <= 8'h00;
         ptr_r      <= 5'h00;
         rw_r       <= 1'b0;
         nack_r     <= 1'b0;
         scl_q      <= 1'b1;
         sda_q      <= 1'b1;
         sda_oe_o   <= 1'b0;
         i2c_wr_r   <= 1'b0;
         i2c_rd_r   <= 1'b0;
         i2c_eidx_r <= 5'h00;
      end else begin
         scl_q    <= scl_s;
         sda_q    <= sda_s;
         i2c_wr_r <= 1'b0;
         i2c_rd_r <= 1'b0;
         if (start) begin
            st_r     <= io_expander_pkg::S_ADDR;
            bit_r    <= 4'h0;
            sda_oe_o <= 1'b0;
         end else if (stop) begin
            st_r     <= io_expander_pkg::S_IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            case (st_r)
               io_expander_pkg::S_ADDR,
               io_expander_pkg::S_PTR,
               io_expander_pkg::S_WDATA: begin
                  if (rise && bit_r != 4'h8) begin
                     sh_r  <= {sh_r[6:0], sda_s};
                     bit_r <= bit_r + 4'h1;
                  end else if (fall && bit_r == 4'h8) begin
                     bit_r <= 4'h0;
                     if (st_r == io_expander_pkg::S_ADDR) begin
                        if (match) begin
                           sda_oe_o <= 1'b1;
                           rw_r     <= sh_r[0];
                           st_r     <= io_expander_pkg::S_AACK;
                        end else begin
                           st_r <= io_expander_pkg::S_IDLE;
                        end
                     end else begin
                        sda_oe_o <= 1'b1;
                        st_r     <= io_expander_pkg::S_DACK;
                        if (st_r == io_expander_pkg::S_PTR) begin
                           ptr_r <= sh_r[4:0]; // R20
                        end else begin
                           i2c_wr_r   <= 1'b1; // R20
                           i2c_eidx_r <= ptr_r;
                           ptr_r      <= ptr_r + 5'h01;
                        end
                     end
                  end
               end
               io_expander_pkg::S_AACK: begin
                  if (fall && rw_r) begin
                     tx_r       <= rd_byte; // R20
                     sda_oe_o   <= ~rd_byte[7];
                     i2c_rd_r   <= 1'b1;
                     i2c_eidx_r <= ptr_r;
                     ptr_r      <= ptr_r + 5'h01;
                     bit_r      <= 4'h0;
                     st_r       <= io_expander_pkg::S_RDATA;
                  end else if (fall) begin
                     sda_oe_o <= 1'b0;
                     st_r     <= io_expander_pkg::S_PTR;
                  end
               end
               io_expander_pkg::S_DACK: begin
                  if (fall) begin
                     sda_oe_o <= 1'b0;
                     st_r     <= io_expander_pkg::S_WDATA;
                  end
               end
               io_expander_pkg::S_RDATA: begin
                  if (fall && bit_r == 4'h7) begin
                     sda_oe_o <= 1'b0;
                     st_r     <= io_expander_pkg::S_RACK;
                  end else if (fall) begin
                     bit_r    <= bit_r + 4'h1;
                     tx_r     <= {tx_r[6:0], 1'b0};
                     sda_oe_o <= ~tx_r[6];
                  end
               end
               io_expander_pkg::S_RACK: begin
                  if (rise) begin
                     nack_r <= sda_s;
                  end else if (fall && nack_r) begin
                     st_r <= io_expander_pkg::S_IDLE;
                  end else if (fall) begin
                     tx_r       <= rd_byte;
                     sda_oe_o   <= ~rd_byte[7];
                     i2c_rd_r   <= 1'b1;
                     i2c_eidx_r <= ptr_r;
                     ptr_r      <= ptr_r + 5'h01;
                     bit_r      <= 4'h0;
                     st_r       <= io_expander_pkg::S_RDATA;
                  end
               end
               default: st_r <= io_expander_pkg::S_IDLE;
            endcase
         end
      end
   end

   input_boot_a: assert property ( // R2
      @(posedge clk_i) disable iff (rst_i)
      $fell(rst_any) |-> cfg_r == 16'hFFFF ##1 gpio_oe_o == 16'h0000)
      else $error("Lines are not all inputs after reset.");

   mask_reset_a: assert property ( // R6
      @(posedge clk_i) disable iff (rst_i)
      $fell(rst_any) |-> mask_r == 16'hFFFF && !irq_oe_o)
      else $error("Interrupt masks are not all set after reset.");

   dir_apply_a: assert property ( // R3
      @(posedge clk_i) disable iff (rst_any)
      !rst_any |=> (gpio_oe_o & $past(cfg_r)) == 16'h0000)
      else $error("An input line is being driven.");

   push_pull_a: assert property ( // R14
      @(posedge clk_i) disable iff (rst_any)
      !odm_r[0] |=> gpio_oe_o[7:0] == ~$past(cfg_r[7:0])
                    && gpio_o[7:0] == $past(out_r[7:0]))
      else $error("Push-pull bank does not follow its registers.");

   open_drain_a: assert property ( // R14
      @(posedge clk_i) disable iff (rst_any)
      odm_r[1] |=> gpio_o[15:8] == 8'h00
                   && gpio_oe_o[15:8] == (~$past(cfg_r[15:8]) & ~$past(out_r[15:8])))
      else $error("Open-drain bank drives a high level.");

   polarity_a: assert property ( // R5
      @(posedge clk_i) disable iff (rst_any)
      wb_go && !we_i && adr_i[7:2] == 6'h00 && hold_r[7:0] == 8'h00
      |=> dat_o[7:0] == ($past(pin_s[7:0]) ^ $past(pol_r[7:0])))
      else $error("Input read ignores the polarity setting.");

   irq_follow_a: assert property ( // R9
      @(posedge clk_i) disable iff (rst_any)
      !rst_any |=> irq_oe_o == (|$past(status)) && !irq_n_o)
      else $error("Interrupt pin does not follow the pending lines.");

   mask_gate_a: assert property ( // R12
      @(posedge clk_i) disable iff (rst_any)
      mask_r == 16'hFFFF |=> !irq_oe_o)
      else $error("Fully masked device raised an interrupt.");

   latch_keep_a: assert property ( // R11
      @(posedge clk_i) disable iff (rst_any)
      hold_r[0] && !clr[0] |=> hold_r[0] && $stable(cap_r[0]))
      else $error("Latched input value changed before a read.");

   addr_ack_a: assert property ( // R18
      @(posedge clk_i) disable iff (rst_any)
      st_r == io_expander_pkg::S_ADDR && fall && !start && !stop
      && bit_r == 4'h8 && match
      |=> sda_oe_o && st_r == io_expander_pkg::S_AACK)
      else $error("Own slave address was not acknowledged.");

   ack_pulse_a: assert property (
      @(posedge clk_i) disable iff (rst_any)
      ack_o |=> !ack_o)
      else $error("Bus acknowledge lasted more than one cycle.");
endmodule
`default_nettype wire

// ===== verification/serial_master_model.sv
/*
 Behavioural serial bus master for the far side of the I/O expander.
 Assumes an open-drain data line with a pull-up that the bench resolves.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_master_model (
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_pull_o
);
   logic mclk;
   // Own clock, offset so that the link never lines up with the system clock.
   initial begin
      mclk = 1'h0;
      scl_o = 1'h1;
      sda_pull_o = 1'h0;
      #3;
      forever #5 mclk = ~mclk;
   end
   task automatic put(input logic b, output logic r);
      @(posedge mclk);
      sda_pull_o <= ~b;
      repeat (3) @(posedge mclk);
      scl_o <= 1'h1;
      repeat (4) @(posedge mclk);
      r = sda_i;
      scl_o <= 1'h0;
   endtask
   // Also serves as repeated start, since it first lifts both lines.
   task automatic start();
      @(posedge mclk);
      sda_pull_o <= 1'h0;
      repeat (3) @(posedge mclk);
      scl_o <= 1'h1;
      repeat (4) @(posedge mclk);
      sda_pull_o <= 1'h1;
      repeat (4) @(posedge mclk);
      scl_o <= 1'h0;
   endtask
   task automatic stop();
      @(posedge mclk);
      sda_pull_o <= 1'h1;
      repeat (3) @(posedge mclk);
      scl_o <= 1'h1;
      repeat (4) @(posedge mclk);
      sda_pull_o <= 1'h0;
      repeat (4) @(posedge mclk);
   endtask
   // Sends d most significant bit first, then drives last in the answer slot.
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put(d[i], r);
         q[i] = r;
      end
      put(last, r);
      ack = ~r;
   endtask
endmodule
`default_nettype wire

// ===== verification/i2c_sixteen_bit_io_expander_bench.sv
/*
 Self-checking bench for the I/O expander: Wishbone tasks, pin model, serial master.
 Assumes the design files and the serial master model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module i2c_sixteen_bit_io_expander_bench;
   logic        clk_i = 1'h0, rst_i = 1'h1, reset_n_i = 1'h1, addr_sel_i = 1'h1;
   logic        cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
   logic [7:0]  adr_i = 8'h00, r, sq;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, w;
   logic [15:0] ext = 16'h0;
   logic [7:0]  expq[$];
   int          seed, n_mismatch = 0, cmp_count = 0;
   wire         sda_o, sda_oe_o, ack_o, irq_n_o, irq_oe_o, scl, m_pull;
   wire [31:0]  dat_o, drive_o;
   wire [15:0]  gpio_o, gpio_oe_o, pull_en_o, pull_up_o;
   wire         sda_line = ~m_pull & ~(sda_oe_o & ~sda_o);
   wire         irq_line = ~(irq_oe_o & ~irq_n_o);
   // An externally driven pin overrides the weak pull, so pulls show only at the ports.
   wire [15:0]  pins = (gpio_oe_o & gpio_o) | (~gpio_oe_o & ext);

   io_expander i_io_expander (.clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
      .addr_sel_i(addr_sel_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .gpio_i(pins),
      .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o), .pull_en_o(pull_en_o),
      .pull_up_o(pull_up_o), .drive_o(drive_o), .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o));
   serial_master_model i_serial_master_model (.sda_i(sda_line), .scl_o(scl),
      .sda_pull_o(m_pull));

   always #5 clk_i = ~clk_i;

   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wb(input logic wr_en, input logic [5:0] i, input logic [7:0] d);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i <= wr_en;
      adr_i <= {i, 2'h0};
      sel_i <= 4'hF;
      dat_i <= {24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'h1);
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      wb(1'h1, i, d);
   endtask
   task automatic rd(input logic [5:0] i, input logic [7:0] e);
      expq.push_back(e);
      wb(1'h0, i, 8'h00);
   endtask
   task automatic sb(input logic [7:0] d, input logic last, input logic exp_ack);
      logic a;
      i_serial_master_model.xfer(d, last, sq, a);
      chk("serial ack", a, exp_ack);
   endtask
   function automatic logic [7:0] dflt(input int i);
      case (i)
         0: return ext[7:0];
         1: return ext[15:8];
         2, 3, 6, 7, 8, 9, 10, 11, 16, 17, 18, 19: return 8'hFF;
         default: return 8'h00;
      endcase
   endfunction

   always @(posedge clk_i) begin
      if (ack_o === 1'h1 && we_i === 1'h0) begin
         if (expq.size() == 0)
            chk("unexpected read", 32'h1, 32'h0);
         else
            chk("read data", dat_o, {24'h0, expq.pop_front()});
      end
   end

   initial begin
      tick(20000);
      n_mismatch++;
      stop_test();
   end

   initial begin
      seed = 32'hF1555DC4;
      ext = 16'($random(seed));
      tick(6);
      rst_i <= 1'h0;
      tick(4);
      chk("dir", gpio_oe_o, 32'h0);
      chk("irq idle", irq_line, 32'h1);
      chk("drive", drive_o, 32'hFFFFFFFF);
      for (int i = 0; i <= 23; i++) rd(6'(i), dflt(i));
      $display("test defaults done");
      r = 8'($random(seed));
      wr(6, 8'h00);
      wr(2, r);
      tick(3);
      chk("oe", gpio_oe_o, 32'h00FF);
      chk("out", gpio_o[7:0], r);
      rd(0, r);
      wr(22, 8'h03);
      tick(2);
      chk("open drain", {gpio_o, gpio_oe_o[7:0]}, {16'h0000, ~r});
      wr(22, 8'h00);
      wr(6, 8'hFF);
      tick(3);
      chk("back to input", gpio_oe_o, 32'h0);
      r = 8'($random(seed));
      wr(5, r);
      rd(1, ext[15:8] ^ r);
      wr(5, 8'h00);
      wr(4, ~r);
      rd(0, ext[7:0] ^ ~r);
      wr(4, 8'h00);
      $display("test direction done");
      for (int i = 0; i < 4; i++) begin
         r = 8'($random(seed));
         wr(6'(8 + i), r);
         w[i*8 +: 8] = r;
      end
      chk("strength", drive_o, w);
      wr(14, 8'h5A);
      wr(16, 8'h3C);
      chk("pulls", {pull_en_o[7:0], pull_up_o[15:0]}, 32'h5AFF3C);
      $display("test pins done");
      ext[0] <= ~ext[0];
      tick(6);
      chk("masked", irq_line, 32'h1);
      rd(0, ext[7:0]);
      wr(18, 8'hFE);
      ext[0] <= ~ext[0];
      tick(4);
      chk("irq low", {irq_line, irq_oe_o}, 32'h1);
      rd(20, 8'h01);
      rd(0, ext[7:0]);
      tick(2);
      chk("cleared by read", irq_line, 32'h1);
      ext[0] <= ~ext[0];
      tick(4);
      ext[0] <= ~ext[0];
      tick(4);
      chk("cleared by return", irq_line, 32'h1);
      wr(12, 8'h01);
      r = ext[7:0];
      ext[0] <= ~ext[0];
      tick(4);
      ext[0] <= ~ext[0];
      tick(4);
      chk("latched irq", irq_line, 32'h0);
      rd(0, r ^ 8'h01);
      rd(0, r);
      wr(12, 8'h00);
      wr(18, 8'hFF);
      $display("test interrupt done");
      i_serial_master_model.start();
      sb(8'h42, 1'h1, 1'h1);
      sb(8'h03, 1'h1, 1'h1);
      sb(8'hA5, 1'h1, 1'h1);
      sb(8'h00, 1'h1, 1'h1);
      i_serial_master_model.stop();
      tick(1);
      rd(3, 8'hA5);
      rd(4, 8'h00);
      i_serial_master_model.start();
      sb(8'h42, 1'h1, 1'h1);
      sb(8'h03, 1'h1, 1'h1);
      i_serial_master_model.start();
      sb(8'h43, 1'h1, 1'h1);
      sb(8'hFF, 1'h1, 1'h0);
      chk("serial read", sq, 32'hA5);
      i_serial_master_model.stop();
      i_serial_master_model.start();
      sb(8'h40, 1'h1, 1'h0);
      i_serial_master_model.stop();
      tick(1);
      $display("test serial done");
      wr(3, 8'h00);
      reset_n_i <= 1'h0;
      tick(4);
      reset_n_i <= 1'h1;
      tick(4);
      rd(3, 8'hFF);
      $display("test reset pin done");
      tick(4);
      stop_test();
   end
endmodule
`default_nettype wire
